// ---- dv/framer_events.sv ----
/*
 * Behavioural receive framer seen from the counter bank: emits bursts of
 * slip, loss-of-frame, lock, checksum or pattern events on request.
 * Assumes the bench raises go for one cycle, after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module framer_events
   import performance_monitor_pkg::*;
(
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       go,
   input  wire logic [2:0] kind,
   input  wire logic [9:0] n,
   input  wire logic [7:0] pos,
   output logic            slip_repeat,
   output logic            slip_drop,
   output logic            lof_declared,
   output logic            frame_locked,
   output logic      [7:0] locked_position,
   output logic      [7:0] offline_position,
   output logic            link1_checksum_error,
   output logic            pattern_error,
   output logic            busy
);
   logic [9:0] left;
   logic [2:0] sel;
   logic       gap;
   logic       ev;
   logic       alt;

   // ----------------------------------------------------------
   // burst sequencer: one event every second cycle
   // ----------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         left <= 10'h000;
         sel  <= 3'h0;
         gap  <= 1'b0;
         ev   <= 1'b0;
         alt  <= 1'b0;
      end else begin
         ev <= 1'b0;
         if (go) begin
            sel  <= kind;
            left <= n - 10'h001;
            ev   <= 1'b1;
            gap  <= 1'b1;
         end else if (gap) begin
            gap <= 1'b0;
         end else if (left != 10'h000) begin
            left <= left - 10'h001;
            ev   <= 1'b1;
            gap  <= 1'b1;
            alt  <= ~alt;
         end
      end
   end

   // ----------------------------------------------------------
   // event lines
   // ----------------------------------------------------------
   assign busy        = (left != 10'h000) || gap;
   assign slip_repeat = ev && ((sel == 3'h0 && !alt) || sel == 3'h1);
   assign slip_drop   = ev && ((sel == 3'h0 && alt) || sel == 3'h1);
   // level drops between declarations so each one is a fresh rise;
   // kind seven holds a single declaration across the whole burst
   assign lof_declared = (ev && sel == 3'h2)
                         || (sel == 3'h7 && busy);
   assign frame_locked = ev && (sel == 3'h3 || sel == 3'h4);
   assign locked_position  = pos;
   assign offline_position = (sel == 3'h4) ? pos : ~pos;
   assign link1_checksum_error = ev && sel == 3'h5;
   assign pattern_error        = ev && sel == 3'h6;
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
/*
 * Self-checking bench of the counter bank: AHB-Lite host, framer model.
 * Assumes the zero-wait slave and addresses of the shared header.
 */
`timescale 1ns/1ps
`default_nettype none
`include "performance_monitor_cfg.svh"
module tb
   import performance_monitor_pkg::*;
;
   logic        hclk, hresetn, hsel, hwrite;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize, kind;
   logic        hreadyout, hresp, irq, go, busy, dphase;
   logic [9:0]  n;
   logic [7:0]  pos, lpos, opos;
   logic        srep, sdrop, lof, lock, cks, perr;
   logic [31:0] exp_q[$];
   int          n_mismatch, n_checks, cyc, seed;
   logic [9:0]  v;
   reg_idx_t    idx[9];

   e1_perf_monitor_counters i_e1_perf_monitor_counters (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .slip_repeat(srep), .slip_drop(sdrop),
      .lof_declared(lof), .frame_locked(lock), .locked_position(lpos),
      .offline_position(opos), .link1_checksum_error(cks),
      .pattern_error(perr), .irq(irq));

   framer_events i_framer_events (
      .hclk(hclk), .hresetn(hresetn), .go(go), .kind(kind), .n(n),
      .pos(pos), .slip_repeat(srep), .slip_drop(sdrop),
      .lof_declared(lof), .frame_locked(lock), .locked_position(lpos),
      .offline_position(opos), .link1_checksum_error(cks),
      .pattern_error(perr), .busy(busy));

   // ----------------------------------------------------------
   // checking and closing
   // ----------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] s,
                      input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   function automatic logic [31:0] ba(input reg_idx_t i);
      return {18'h00000, i, 2'b00};
   endfunction

   // ----------------------------------------------------------
   // host and framer drivers
   // ----------------------------------------------------------
   task automatic ahb_rd(input reg_idx_t i, input logic [31:0] e);
      exp_q.push_back(e);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= ba(i);
      htrans <= 2'b10;
      hwrite <= 1'b0;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
      htrans <= 2'b00;
      hsel   <= 1'b0;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
   endtask

   task automatic ahb_wr(input reg_idx_t i, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= ba(i);
      htrans <= 2'b10;
      hwrite <= 1'b1;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
      htrans <= 2'b00;
      hsel   <= 1'b0;
      hwdata <= d;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
   endtask

   // go is raised right away so a burst can meet a read's address edge
   task automatic fire(input logic [2:0] k3, input logic [9:0] c);
      kind <= k3;
      n    <= c;
      pos  <= 8'($random(seed));
      go   <= 1'b1;
      @(posedge hclk);
      go <= 1'b0;
      @(posedge hclk);
      while (busy) @(posedge hclk);
   endtask

   // ----------------------------------------------------------
   // read data monitor: oldest note against each data phase
   // ----------------------------------------------------------
   always @(posedge hclk) begin
      if (dphase && hreadyout && exp_q.size() > 0) begin
         chk("hrdata", hrdata, exp_q.pop_front());
         chk("hresp", {31'h0, hresp}, 32'h0);
      end
      dphase <= hsel && htrans[1] && hreadyout && !hwrite;
   end

   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         print_verdict();
      end
   end

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      {hsel, hwrite, go, dphase} = 4'h0;
      {haddr, hwdata} = 64'h0;
      htrans = 2'b00;
      hsize = 3'b010;
      kind = 3'h0;
      n = 10'h001;
      pos = 8'h00;
      seed = 69;
      hresetn = 1'b0;
      idx = '{`PERFORMANCE_MONITOR_IDX_SLIP, `PERFORMANCE_MONITOR_IDX_LOF, `PERFORMANCE_MONITOR_IDX_REALIGN,
              `PERFORMANCE_MONITOR_IDX_CHECKSUM, `PERFORMANCE_MONITOR_IDX_PAT_HIGH, `PERFORMANCE_MONITOR_IDX_PAT_LOW,
              `PERFORMANCE_MONITOR_IDX_IRQ_STAT, `PERFORMANCE_MONITOR_IDX_IRQ_MASK, 12'h910};
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (idx[j]) ahb_rd(idx[j], 32'h0);
      fire(3'h0, 10'd3);
      fire(3'h1, 10'd1);
      ahb_rd(`PERFORMANCE_MONITOR_IDX_SLIP, 32'h4);
      ahb_rd(`PERFORMANCE_MONITOR_IDX_SLIP, 32'h0);
      fire(3'h2, 10'd5);
      ahb_rd(`PERFORMANCE_MONITOR_IDX_LOF, 32'h5);
      fire(3'h7, 10'd3);
      ahb_rd(`PERFORMANCE_MONITOR_IDX_LOF, 32'h1);
      fire(3'h3, 10'd3);
      fire(3'h4, 10'd2);
      ahb_rd(`PERFORMANCE_MONITOR_IDX_REALIGN, 32'h3);
      ahb_rd(`PERFORMANCE_MONITOR_IDX_REALIGN, 32'h0);
      v = 10'(1 + $unsigned($random(seed)) % 20);
      fire(3'h5, v);
      ahb_rd(`PERFORMANCE_MONITOR_IDX_CHECKSUM, {22'h0, v});
      fire(3'h0, 10'd300);
      ahb_rd(`PERFORMANCE_MONITOR_IDX_SLIP, 32'hFF);
      ahb_rd(`PERFORMANCE_MONITOR_IDX_SLIP, 32'h0);
      // pattern pair: upper then lower, then an unpaired lower
      v = 10'(256 + $unsigned($random(seed)) % 200);
      fire(3'h6, v);
      ahb_rd(`PERFORMANCE_MONITOR_IDX_PAT_HIGH, {30'h0, v[9:8]});
      ahb_rd(`PERFORMANCE_MONITOR_IDX_PAT_LOW, {24'h0, v[7:0]});
      ahb_rd(`PERFORMANCE_MONITOR_IDX_PAT_HIGH, 32'h0);
      ahb_rd(`PERFORMANCE_MONITOR_IDX_PAT_LOW, 32'h0);
      v = 10'(1 + $unsigned($random(seed)) % 50);
      fire(3'h6, v);
      ahb_rd(`PERFORMANCE_MONITOR_IDX_PAT_LOW, {22'h0, v});
      ahb_rd(`PERFORMANCE_MONITOR_IDX_PAT_LOW, {22'h0, v});
      ahb_rd(`PERFORMANCE_MONITOR_IDX_PAT_HIGH, 32'h0);
      ahb_rd(`PERFORMANCE_MONITOR_IDX_PAT_LOW, {22'h0, v});
      // slip lands on the clearing read's address edge
      fork
         ahb_rd(`PERFORMANCE_MONITOR_IDX_SLIP, 32'h0);
         fire(3'h0, 10'd1);
      join
      ahb_rd(`PERFORMANCE_MONITOR_IDX_SLIP, 32'h1);
      ahb_wr(`PERFORMANCE_MONITOR_IDX_IRQ_STAT, 32'h1F);
      ahb_wr(`PERFORMANCE_MONITOR_IDX_IRQ_MASK, 32'h01);
      ahb_rd(`PERFORMANCE_MONITOR_IDX_IRQ_STAT, 32'h0);
      fire(3'h5, 10'd1);
      repeat (3) @(posedge hclk);
      chk("irq", {31'h0, irq}, 32'h0);
      ahb_rd(`PERFORMANCE_MONITOR_IDX_IRQ_STAT, 32'h08);
      fire(3'h0, 10'd1);
      repeat (3) @(posedge hclk);
      chk("irq", {31'h0, irq}, 32'h1);
      ahb_wr(`PERFORMANCE_MONITOR_IDX_IRQ_STAT, 32'h01);
      repeat (3) @(posedge hclk);
      chk("irq", {31'h0, irq}, 32'h0);
      ahb_rd(`PERFORMANCE_MONITOR_IDX_IRQ_MASK, 32'h01);
      ahb_rd(`PERFORMANCE_MONITOR_IDX_IRQ_STAT, 32'h08);
      // a byte-sized read returns zero without clearing and a counter write is ignored
      hsize <= 3'b000;
      ahb_rd(`PERFORMANCE_MONITOR_IDX_SLIP, 32'h0);
      hsize <= 3'b010;
      ahb_wr(`PERFORMANCE_MONITOR_IDX_SLIP, 32'hFF);
      ahb_rd(`PERFORMANCE_MONITOR_IDX_SLIP, 32'h1);
      ahb_rd(`PERFORMANCE_MONITOR_IDX_CHECKSUM, 32'h1);
      repeat (4) @(posedge hclk);
      print_verdict();
   end
endmodule
`default_nettype wire

// ---- shared/performance_monitor_cfg.svh ----
/*
 * Offsets, field positions and reset values of the counter bank.
 * Assumes inclusion by bare name from bench and design files.
 */
`ifndef PERFORMANCE_MONITOR_CFG_SVH
`define PERFORMANCE_MONITOR_CFG_SVH

// ------------------------------------------------------------
// register indices; byte address is four times the index
// ------------------------------------------------------------
`define PERFORMANCE_MONITOR_IDX_SLIP      12'h909
`define PERFORMANCE_MONITOR_IDX_LOF       12'h90A
`define PERFORMANCE_MONITOR_IDX_REALIGN   12'h90B
`define PERFORMANCE_MONITOR_IDX_CHECKSUM  12'h90C
`define PERFORMANCE_MONITOR_IDX_PAT_HIGH  12'h90D
`define PERFORMANCE_MONITOR_IDX_PAT_LOW   12'h90E
`define PERFORMANCE_MONITOR_IDX_IRQ_STAT  12'h920
`define PERFORMANCE_MONITOR_IDX_IRQ_MASK  12'h921

// ------------------------------------------------------------
// interrupt field positions and reset values
// ------------------------------------------------------------
`define PERFORMANCE_MONITOR_IRQ_SLIP      0
`define PERFORMANCE_MONITOR_IRQ_LOF       1
`define PERFORMANCE_MONITOR_IRQ_REALIGN   2
`define PERFORMANCE_MONITOR_IRQ_CHECKSUM  3
`define PERFORMANCE_MONITOR_IRQ_PATTERN   4
`define PERFORMANCE_MONITOR_IRQ_BITS      5
`define PERFORMANCE_MONITOR_CNT_RESET     8'h00
`define PERFORMANCE_MONITOR_MASK_RESET    5'h00

`endif

// ---- shared/performance_monitor_if.sv ----
/*
 * Read-and-clear links between the register front end and counters.
 * Assumes one clock; strobes are single-cycle pulses from the bus side.
 */
`timescale 1ns/1ps
`default_nettype none
interface count_if #(parameter int W = 8);
   logic         rd;
   logic [W-1:0] count;
   modport ctr  (input rd, output count);
   modport host (output rd, input count);
endinterface

interface pair_if;
   logic       rd_high;
   logic       rd_low;
   logic [7:0] high;
   logic [7:0] low;
   modport ctr  (input rd_high, rd_low, output high, low);
   modport host (output rd_high, rd_low, input high, low);
endinterface
`default_nettype wire

// ---- shared/performance_monitor_pkg.sv ----
/*
 * Types and the shared saturating step of the counter bank.
 * Assumes counters no wider than sixteen bits.
 */
`default_nettype none
package performance_monitor_pkg;
   typedef logic [15:0] count_t;
   typedef logic [11:0] reg_idx_t;

   // clear wins over the held value, never over a new event
   function automatic count_t sat_step(input count_t cur,
                                       input count_t top,
                                       input logic   inc,
                                       input logic   clr);
      count_t res;
      res = cur;
      if (clr)
         res = inc ? 16'h0001 : 16'h0000;
      else if (inc && cur != top)
         res = cur + 16'h0001;
      return res;
   endfunction
endpackage
`default_nettype wire

// ---- src/e1_perf_monitor_counters.sv ----
/*
 * Performance-monitor counter bank of one E1 receive channel, with an
 * AHB-Lite register slave and a masked sticky interrupt.
 * Assumes all event inputs come from framer logic on hclk, as one-cycle
 * pulses except lof_declared, which is a level.
 */
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "performance_monitor_cfg.svh"

module e1_perf_monitor_counters
   import performance_monitor_pkg::*;
#(
   parameter int POS_W = 8
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic             hsel,
   input  wire logic [31:0]      haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output logic      [31:0]      hrdata,
   output logic                  hreadyout,
   output logic                  hresp,
   input  wire logic             slip_repeat,
   input  wire logic             slip_drop,
   input  wire logic             lof_declared,
   input  wire logic             frame_locked,
   input  wire logic [POS_W-1:0] locked_position,
   input  wire logic [POS_W-1:0] offline_position,
   input  wire logic             link1_checksum_error,
   input  wire logic             pattern_error,
   output logic                  irq
);
   // ------------------------------------------------------------
   // address phase decode
   // ------------------------------------------------------------
   logic     take;
   logic     rd_take;
   logic     wr_take;
   reg_idx_t idx;

   // only whole aligned words inside the bank's 16 KB window are mapped
   function automatic logic word_ok(input logic [31:0] a,
                                    input logic [2:0]  s);
      return (a[31:14] == 18'h00000) && (a[1:0] == 2'b00)
             && (s == 3'b010);
   endfunction

   function automatic logic hit(input reg_idx_t a, input reg_idx_t b);
      return a == b;
   endfunction

   assign take    = hsel && htrans[1] && hready
                    && word_ok(haddr, hsize);
   assign rd_take = take && !hwrite;
   assign wr_take = take && hwrite;
   assign idx     = haddr[13:2];

   // ------------------------------------------------------------
   // event shaping
   // ------------------------------------------------------------
   logic slip_ev;
   logic lof_prev;
   logic lof_ev;
   logic realign_ev;

   assign slip_ev    = slip_repeat || slip_drop;
   assign lof_ev     = lof_declared && !lof_prev;
   assign realign_ev = frame_locked
                       && (locked_position != offline_position);

   // a long outage is one declaration, so only the rising edge counts
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         lof_prev <= 1'b0;
      else
         lof_prev <= lof_declared;
   end

   // ------------------------------------------------------------
   // counters
   // ------------------------------------------------------------
   count_if #(.W(8)) slip_c ();
   count_if #(.W(8)) lof_c ();
   count_if #(.W(8)) realign_c ();
   count_if #(.W(8)) checksum_c ();
   pair_if           pattern_c ();

   // the clear happens on the same edge that captures read data
   assign slip_c.rd     = rd_take && hit(idx, `PERFORMANCE_MONITOR_IDX_SLIP);
   assign lof_c.rd      = rd_take && hit(idx, `PERFORMANCE_MONITOR_IDX_LOF);
   assign realign_c.rd  = rd_take && hit(idx, `PERFORMANCE_MONITOR_IDX_REALIGN);
   assign checksum_c.rd = rd_take && hit(idx, `PERFORMANCE_MONITOR_IDX_CHECKSUM);
   assign pattern_c.rd_high = rd_take
                              && hit(idx, `PERFORMANCE_MONITOR_IDX_PAT_HIGH);
   assign pattern_c.rd_low  = rd_take
                              && hit(idx, `PERFORMANCE_MONITOR_IDX_PAT_LOW);

   event_counter #(.W(8)) u_slip (
      .hclk    (hclk),
      .hresetn (hresetn),
      .inc     (slip_ev),
      .port    (slip_c)
   );

   event_counter #(.W(8)) u_lof (
      .hclk    (hclk),
      .hresetn (hresetn),
      .inc     (lof_ev),
      .port    (lof_c)
   );

   event_counter #(.W(8)) u_realign (
      .hclk    (hclk),
      .hresetn (hresetn),
      .inc     (realign_ev),
      .port    (realign_c)
   );

   event_counter #(.W(8)) u_checksum (
      .hclk    (hclk),
      .hresetn (hresetn),
      .inc     (link1_checksum_error),
      .port    (checksum_c)
   );

   pair_counter u_pattern (
      .hclk    (hclk),
      .hresetn (hresetn),
      .inc     (pattern_error),
      .port    (pattern_c)
   );

   // ------------------------------------------------------------
   // interrupt status and mask
   // ------------------------------------------------------------
   logic [`PERFORMANCE_MONITOR_IRQ_BITS-1:0] irq_status;
   logic [`PERFORMANCE_MONITOR_IRQ_BITS-1:0] irq_mask;
   logic [`PERFORMANCE_MONITOR_IRQ_BITS-1:0] events;
   logic [`PERFORMANCE_MONITOR_IRQ_BITS-1:0] stat_clear;
   logic [`PERFORMANCE_MONITOR_IRQ_BITS-1:0] next_status;
   logic                      wr_pend;
   reg_idx_t                  wr_idx;

   always_comb begin
      events = '0;
      events[`PERFORMANCE_MONITOR_IRQ_SLIP]     = slip_ev;
      events[`PERFORMANCE_MONITOR_IRQ_LOF]      = lof_ev;
      events[`PERFORMANCE_MONITOR_IRQ_REALIGN]  = realign_ev;
      events[`PERFORMANCE_MONITOR_IRQ_CHECKSUM] = link1_checksum_error;
      events[`PERFORMANCE_MONITOR_IRQ_PATTERN]  = pattern_error;
   end

   assign stat_clear  = (wr_pend && hit(wr_idx, `PERFORMANCE_MONITOR_IDX_IRQ_STAT))
                        ? hwdata[`PERFORMANCE_MONITOR_IRQ_BITS-1:0] : '0;
   // a new event beats a write-one-to-clear in the same cycle
   assign next_status = (irq_status & ~stat_clear) | events;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_idx  <= 12'h000;
      end else begin
         wr_pend <= wr_take;
         wr_idx  <= idx;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         irq_status <= '0;
      else
         irq_status <= next_status;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         irq_mask <= `PERFORMANCE_MONITOR_MASK_RESET;
      else if (wr_pend && hit(wr_idx, `PERFORMANCE_MONITOR_IDX_IRQ_MASK))
         irq_mask <= hwdata[`PERFORMANCE_MONITOR_IRQ_BITS-1:0];
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         irq <= 1'b0;
      else
         irq <= |(irq_status & irq_mask);
   end

   // ------------------------------------------------------------
   // read data and response
   // ------------------------------------------------------------
   logic [31:0] read_word;

   always_comb begin
      read_word = 32'h00000000;
      case (idx)
         `PERFORMANCE_MONITOR_IDX_SLIP:     read_word[7:0] = slip_c.count;
         `PERFORMANCE_MONITOR_IDX_LOF:      read_word[7:0] = lof_c.count;
         `PERFORMANCE_MONITOR_IDX_REALIGN:  read_word[7:0] = realign_c.count;
         `PERFORMANCE_MONITOR_IDX_CHECKSUM: read_word[7:0] = checksum_c.count;
         `PERFORMANCE_MONITOR_IDX_PAT_HIGH: read_word[7:0] = pattern_c.high;
         `PERFORMANCE_MONITOR_IDX_PAT_LOW:  read_word[7:0] = pattern_c.low;
         `PERFORMANCE_MONITOR_IDX_IRQ_STAT:
            read_word[`PERFORMANCE_MONITOR_IRQ_BITS-1:0] = irq_status;
         `PERFORMANCE_MONITOR_IDX_IRQ_MASK:
            read_word[`PERFORMANCE_MONITOR_IRQ_BITS-1:0] = irq_mask;
         default:            read_word = 32'h00000000;
      endcase
   end

   // zero wait states; read data is the value before the clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata <= 32'h00000000;
      else if (rd_take)
         hrdata <= read_word;
      else
         hrdata <= 32'h00000000;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence lof_held_s;
      $rose(lof_declared) ##1 lof_declared [*2];
   endsequence

   sequence slip_free_s;
      slip_ev && !slip_c.rd && slip_c.count != 8'hFF;
   endsequence

   // both slip lines in one cycle describe one slipped frame
   sequence slip_pair_s;
      slip_repeat && slip_drop && !slip_c.rd && slip_c.count != 8'hFF;
   endsequence

   sequence stat_wipe_s;
      wr_pend && hit(wr_idx, `PERFORMANCE_MONITOR_IDX_IRQ_STAT) && !(|events);
   endsequence

   slip_count_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      slip_free_s |=> slip_c.count == $past(slip_c.count) + 8'h01)
      else $error("slip event not counted");

   slip_once_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      slip_pair_s |=> slip_c.count == $past(slip_c.count) + 8'h01)
      else $error("one slip counted twice");

   slip_clear_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (slip_c.rd && !slip_ev) |=> (slip_c.count == 8'h00
         && hrdata[7:0] == $past(slip_c.count)))
      else $error("slip read did not return and clear");

   lof_once_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      lof_held_s |-> (!lof_ev && !$past(lof_ev)))
      else $error("held loss of frame counted twice");

   lof_edge_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ($rose(lof_declared) && !lof_c.rd && lof_c.count != 8'hFF)
         |=> lof_c.count == $past(lof_c.count) + 8'h01)
      else $error("loss of frame declaration not counted");

   realign_same_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (frame_locked && locked_position == offline_position
         && !realign_c.rd) |=> realign_c.count == $past(realign_c.count))
      else $error("alignment change counted for same position");

   realign_diff_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (realign_ev && !realign_c.rd && realign_c.count != 8'hFF)
         |=> realign_c.count == $past(realign_c.count) + 8'h01)
      else $error("alignment change not counted");

   read_clear_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      checksum_c.rd |=> (hrdata[7:0] == $past(checksum_c.count)
         && checksum_c.count == {7'h00, $past(link1_checksum_error)}))
      else $error("checksum read did not return and clear");

   pattern_high_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      pattern_c.rd_high |=> hrdata[7:0] == $past(pattern_c.high))
      else $error("upper pattern byte not returned");

   // a stale hold from an unpaired upper read is still what is shown
   pattern_pair_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      pattern_c.rd_low |=> hrdata[7:0] == $past(pattern_c.low))
      else $error("lower pattern byte not returned");

   pair_clear_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      pattern_c.rd_high |=> pattern_c.high == 8'h00)
      else $error("upper read did not restart the count");

   read_idle_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !rd_take |=> hrdata == 32'h00000000)
      else $error("read data outside a data phase");

   status_set_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (|events) |=> (irq_status & $past(events)) == $past(events))
      else $error("event lost against status clear");

   status_clear_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      stat_wipe_s |=> (irq_status & $past(stat_clear)) == '0)
      else $error("written ones did not clear status");

   irq_level_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ##1 irq == $past(|(irq_status & irq_mask)))
      else $error("interrupt level disagrees with masked status");
endmodule
`default_nettype wire

// ---- src/event_counter.sv ----
/*
 * Saturating event counter, cleared by a read strobe.
 * Assumes inc and the read strobe come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module event_counter
   import performance_monitor_pkg::*;
#(
   parameter int W = 8
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic inc,
   count_if.ctr      port
);
   localparam count_t TOP = count_t'((1 << W) - 1);
   count_t step;

   always_comb begin
      step = sat_step({{(16-W){1'b0}}, port.count}, TOP, inc, port.rd);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         port.count <= '0;
      else
         port.count <= step[W-1:0];
   end

   sat_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (port.count == TOP[W-1:0] && !port.rd) |=> port.count == TOP[W-1:0])
      else $error("counter left its ceiling without a read");
   clear_keep_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (port.rd && inc) |=> port.count == W'(1))
      else $error("event lost on the clearing read");
endmodule
`default_nettype wire

// ---- src/pair_counter.sv ----
/*
 * Sixteen-bit saturating counter read as upper then lower byte.
 * Assumes the host reads the upper byte first for a consistent value.
 */
`timescale 1ns/1ps
`default_nettype none
module pair_counter
   import performance_monitor_pkg::*;
(
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic inc,
   pair_if.ctr       port
);
   count_t     count;
   logic [7:0] low_hold;
   logic       hold_valid;
   count_t     step;

   always_comb begin
      step = sat_step(count, 16'hFFFF, inc, port.rd_high);
   end

   // the upper read freezes the lower byte and restarts the count
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         count <= 16'h0000;
      else
         count <= step;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_hold   <= 8'h00;
         hold_valid <= 1'b0;
      end else if (port.rd_high) begin
         low_hold   <= count[7:0];
         hold_valid <= 1'b1;
      end else if (port.rd_low && hold_valid) begin
         low_hold   <= 8'h00;
         hold_valid <= 1'b0;
      end
   end

   assign port.high = count[15:8];
   assign port.low  = hold_valid ? low_hold : count[7:0];

   pair_snap_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      port.rd_high |=> (port.low == $past(count[7:0]) && hold_valid))
      else $error("lower byte not frozen by upper read");
   lone_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (port.rd_low && !hold_valid && !port.rd_high && !inc)
         |=> count == $past(count))
      else $error("lower read alone changed the count");
endmodule
`default_nettype wire
